// *** rtl/sensor_iface_pkg.sv ***
package sensor_iface_pkg;

    // Number of two-channel input pairs; the last one is the cascade pair
    localparam int PAIR_COUNT = 4;
    localparam int CASCADE_IDX = 3;
    localparam int LOCAL_COUNT = 3;

    // Clock period and test pulse timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PULSE_WIDTH_NS = 1000;
    localparam int PULSE_CYCLES = (PULSE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_PERIOD_US = 1000;
    localparam int PERIOD_CYCLES_DEF = (PULSE_PERIOD_US * 1000000) / CLK_PERIOD_PS;

    // Full pulse periods with cascade pair closed before start-up ends
    localparam int STARTUP_ROUNDS = 2;
    localparam logic [1:0] ROUNDS_LAST = 2'h1;
    localparam logic [1:0] ROUNDS_ZERO = 2'h0;

    // Operating phases
    typedef enum logic [1:0] {
        PH_STARTUP,
        PH_RUN,
        PH_FAULT
    } phase_type;

endpackage : sensor_iface_pkg

// *** rtl/pair_check.sv ***
`timescale 1ns/1ps

// One two-channel input pair: steady level, partial-operation block, pulse check
module pair_check
    import sensor_iface_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Channel inputs
    input wire logic ch_a_in,
    input wire logic ch_b_in,
    // Strobes from the pulse sequencer
    input wire logic strobe_idle_in,
    input wire logic strobe_a_in,
    input wire logic strobe_b_in,
    // Results
    output logic closed_out,
    output logic blocked_out,
    output logic fault_out
);

    logic steady_a;
    logic steady_b;
    logic blocked;
    logic fault;
    logic next_steady_a;
    logic next_steady_b;
    logic next_blocked;
    logic next_fault;

    // Steady levels, partial-operation block and cross-short check
    always_comb
    begin
        next_steady_a = strobe_idle_in ? ch_a_in : steady_a;
        next_steady_b = strobe_idle_in ? ch_b_in : steady_b;
        next_blocked = blocked;
        if (steady_a != steady_b)
        begin
            next_blocked = 1'b1;
        end
        else if (!steady_a && !steady_b)
        begin
            next_blocked = 1'b0;
        end
        // A closed channel must be low during its own pulse; a contact that opens
        // between samples reads low as well, so only a high level counts as a short
        next_fault = (strobe_a_in && steady_a && ch_a_in)
            || (strobe_b_in && steady_b && ch_b_in);
    end

    // Register the pair state
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            steady_a <= 1'b0;
            steady_b <= 1'b0;
            blocked <= 1'b0;
            fault <= 1'b0;
        end
        else
        begin
            steady_a <= next_steady_a;
            steady_b <= next_steady_b;
            blocked <= next_blocked;
            fault <= next_fault;
        end
    end

    // Results to the evaluation logic
    assign closed_out = steady_a && steady_b;
    assign blocked_out = blocked;
    assign fault_out = fault;

endmodule : pair_check

// *** rtl/safety_sensor_and_interface.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - Three sensors, each a pair of normally-open contacts, and the cascade pair form four two-channel inputs.
// - Both safety outputs high only while all input circuits are closed.
// - Any open circuit or disagreeing pair drives both safety outputs low.
// - Signal output high while all local sensors are operated and closed.
// - Signal output low once any local sensor is open or partly operated.
// - Two distinct test pulse outputs, each fixed to its own input channels.
// - Wrong pulse or short at an input forces safety outputs low, records error.
// - The last pair takes upstream safety outputs; three sensors remain local.
// - Cross shorts in a cascade also switch the safety outputs low; once cascaded, only the local pairs are pulse-checked, not the cascade pair.
// - Spare input has no function and stays unused.
// - Pulse A serves every first channel, pulse B every second channel.
// - Signal output ignores the cascade pair entirely.
// - Start-up phase decides between stand-alone and cascaded operation.
// - Short faults stay latched with safety outputs low until power is cycled.
module safety_sensor_and_interface
    import sensor_iface_pkg::*;
#(
    parameter int PERIOD_CYCLES = sensor_iface_pkg::PERIOD_CYCLES_DEF
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Local sensor channels
    input wire logic sensor1_ch_a_in,
    input wire logic sensor1_ch_b_in,
    input wire logic sensor2_ch_a_in,
    input wire logic sensor2_ch_b_in,
    input wire logic sensor3_ch_a_in,
    input wire logic sensor3_ch_b_in,
    // Cascade pair, from an upstream unit or tied to the pulses
    input wire logic cascade_ch_a_in,
    input wire logic cascade_ch_b_in,
    // Test pulses, low-going
    output logic test_pulse_a_out,
    output logic test_pulse_b_out,
    // Results
    output logic safety_out_a_out,
    output logic safety_out_b_out,
    output logic signal_out_out,
    output logic error_out,
    output logic ready_out,
    output logic cascaded_out
);

    import sensor_iface_pkg::*;

    localparam int CNT_W = $clog2(PERIOD_CYCLES);
    localparam int HALF = PERIOD_CYCLES / 2;

    // True when the sequencer count sits on a given point
    function automatic logic at_count(input logic [CNT_W-1:0] cnt, input int point);
        at_count = (cnt == CNT_W'(point));
    endfunction : at_count

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic pulse_a;
    logic pulse_b;
    logic next_pulse_a;
    logic next_pulse_b;
    logic strobe_idle;
    logic strobe_a;
    logic strobe_b;
    logic wrap;
    logic [PAIR_COUNT-1:0] ch_a;
    logic [PAIR_COUNT-1:0] ch_b;
    logic [PAIR_COUNT-1:0] closed;
    logic [PAIR_COUNT-1:0] blocked;
    logic [PAIR_COUNT-1:0] fault;

    // Only the eight channel inputs feed the evaluation; spare pin left out
    assign ch_a = {cascade_ch_a_in, sensor3_ch_a_in, sensor2_ch_a_in, sensor1_ch_a_in};
    assign ch_b = {cascade_ch_b_in, sensor3_ch_b_in, sensor2_ch_b_in, sensor1_ch_b_in};

    // Pulse sequencer: pulse A at the start, pulse B half a period later
    always_comb
    begin
        wrap = at_count(count, PERIOD_CYCLES - 1);
        next_count = wrap ? '0 : count + CNT_W'(1);
        next_pulse_a = !(next_count < CNT_W'(PULSE_CYCLES));
        next_pulse_b = !((next_count >= CNT_W'(HALF))
            && (next_count < CNT_W'(HALF + PULSE_CYCLES)));
        strobe_idle = wrap || at_count(count, HALF - 1);
        strobe_a = at_count(count, PULSE_CYCLES - 1);
        strobe_b = at_count(count, HALF + PULSE_CYCLES - 1);
    end

    // Register the sequencer
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            count <= '0;
            pulse_a <= 1'b1;
            pulse_b <= 1'b1;
        end
        else
        begin
            count <= next_count;
            pulse_a <= next_pulse_a;
            pulse_b <= next_pulse_b;
        end
    end

    // One checker per input pair
    for (genvar i = 0; i < PAIR_COUNT; i++)
    begin : g_pair
        pair_check u_pair (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .ch_a_in(ch_a[i]),
            .ch_b_in(ch_b[i]),
            .strobe_idle_in(strobe_idle),
            .strobe_a_in(strobe_a),
            .strobe_b_in(strobe_b),
            .closed_out(closed[i]),
            .blocked_out(blocked[i]),
            .fault_out(fault[i])
        );
    end

    phase_type phase;
    phase_type next_phase;
    logic cascaded;
    logic next_cascaded;
    logic [1:0] rounds;
    logic [1:0] next_rounds;
    logic fault_now;
    logic all_ok;
    logic local_ok;
    logic next_safety;
    logic next_signal;

    // Phase control: start-up detection, run, latched fault
    always_comb
    begin
        next_phase = phase;
        next_cascaded = cascaded;
        next_rounds = rounds;
        // Cascade pair is checked against the pulses only when it is tied to them
        fault_now = (|fault[LOCAL_COUNT-1:0])
            || (fault[CASCADE_IDX] && !cascaded && (phase == PH_RUN));
        all_ok = (&closed) && !(|blocked);
        local_ok = (&closed[LOCAL_COUNT-1:0]) && !(|blocked[LOCAL_COUNT-1:0]);
        unique case (phase)
            PH_STARTUP:
            begin
                // A cascade pair that ignores pulse A or pulse B is fed by an upstream unit
                if (fault[CASCADE_IDX] && strobe_a == 1'b0)
                begin
                    next_cascaded = 1'b1;
                end
                if (wrap)
                begin
                    next_rounds = closed[CASCADE_IDX] ? rounds + 2'h1 : ROUNDS_ZERO;
                    if (closed[CASCADE_IDX] && rounds == ROUNDS_LAST)
                    begin
                        next_phase = PH_RUN;
                    end
                end
                if (fault_now)
                begin
                    next_phase = PH_FAULT;
                end
            end
            PH_RUN:
            begin
                if (fault_now)
                begin
                    next_phase = PH_FAULT;
                end
            end
            PH_FAULT:
            begin
                next_phase = PH_FAULT;
            end
        endcase
        next_safety = (next_phase == PH_RUN) && all_ok;
        next_signal = local_ok;
    end

    // Register phase and outputs
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            phase <= PH_STARTUP;
            cascaded <= 1'b0;
            rounds <= ROUNDS_ZERO;
            safety_out_a_out <= 1'b0;
            safety_out_b_out <= 1'b0;
            signal_out_out <= 1'b0;
            error_out <= 1'b0;
            ready_out <= 1'b0;
            cascaded_out <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            cascaded <= next_cascaded;
            rounds <= next_rounds;
            safety_out_a_out <= next_safety;
            safety_out_b_out <= next_safety;
            signal_out_out <= next_signal;
            error_out <= (next_phase == PH_FAULT);
            ready_out <= (next_phase == PH_RUN);
            cascaded_out <= next_cascaded;
        end
    end

    // Pulses leave straight from their flip-flops
    assign test_pulse_a_out = pulse_a;
    assign test_pulse_b_out = pulse_b;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence pulse_a_low_s;
        !test_pulse_a_out [*8];
    endsequence

    sequence fault_seen_s;
        (phase != PH_FAULT) && fault_now;
    endsequence

    sequence latched_s;
        error_out && !safety_out_a_out && !safety_out_b_out;
    endsequence

    safety_pair_a: assert property (safety_out_a_out == safety_out_b_out)
        else $error("safety outputs disagree");
    safety_closed_a: assert property ($rose(safety_out_a_out) |-> $past(all_ok))
        else $error("safety output rose with an open circuit");
    open_drops_a: assert property (!(&closed) |=> !safety_out_a_out)
        else $error("safety output high with an open circuit");
    partial_block_a: assert property (|blocked |=> !safety_out_b_out)
        else $error("safety output high while a pair is blocked");
    signal_high_a: assert property (local_ok |=> signal_out_out)
        else $error("signal output low with local sensors closed");
    signal_low_a: assert property (!local_ok |=> !signal_out_out)
        else $error("signal output high with a local sensor open");
    pulse_disjoint_a: assert property (test_pulse_a_out || test_pulse_b_out)
        else $error("test pulses overlap");
    pulse_width_a: assert property ($fell(test_pulse_a_out) |-> pulse_a_low_s)
        else $error("test pulse A too short");
    fault_latch_a: assert property (fault_seen_s |=> latched_s ##1 latched_s)
        else $error("fault did not force outputs low");
    fault_hold_a: assert property (error_out |=> latched_s)
        else $error("latched fault released");
    startup_quiet_a: assert property ((phase == PH_STARTUP) |-> !safety_out_a_out)
        else $error("safety output high during start-up");

endmodule : safety_sensor_and_interface

// *** test/sensor_model.sv ***
`timescale 1ns/1ps

// Sensors and upstream unit: closed contacts carry their pulse, open ones read low
module sensor_model
(
    // Pulses from the unit
    input wire logic test_pulse_a_in,
    input wire logic test_pulse_b_in,
    // Contact states and faults, bit 3 is the cascade pair
    input wire logic [3:0] closed_a_in,
    input wire logic [3:0] closed_b_in,
    input wire logic [3:0] swap_in,
    input wire logic casc_mode_in,
    // Channel levels
    output logic [3:0] ch_a_out,
    output logic [3:0] ch_b_out
);
    // Contact wiring; a swapped channel b follows pulse A instead
    always_comb
    begin
        ch_a_out = closed_a_in & {4{test_pulse_a_in}};
        for (int i = 0; i < 4; i++)
        begin
            ch_b_out[i] = closed_b_in[i] & (swap_in[i] ? test_pulse_a_in : test_pulse_b_in);
        end
        // Upstream safety outputs are steady levels on the cascade pair
        if (casc_mode_in)
        begin
            ch_a_out[3] = closed_a_in[3];
            ch_b_out[3] = closed_b_in[3];
        end
    end
endmodule : sensor_model

// *** test/safety_sensor_and_interface_tb.sv ***
`timescale 1ns/1ps

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end

// No spare input exists at the ports, so none is driven
module safety_sensor_and_interface_tb;
    import sensor_iface_pkg::*;
    localparam int PER = 1024;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] cl_a = 4'hf;
    logic [3:0] cl_b = 4'hf;
    logic [3:0] swap = 4'h0;
    logic casc_mode = 1'b0;
    logic [3:0] ch_a;
    logic [3:0] ch_b;
    logic tpa, tpb, sa, sb, so, err, rdy, casc;
    int fails = 0;
    int num_checks = 0;
    int seed = 32'haf654806;
    int overlap = 0;
    logic [31:0] r;
    logic [3:0] a, b;

    // Clock
    initial forever #2.5 clk_in = ~clk_in;

    sensor_model model (.test_pulse_a_in(tpa), .test_pulse_b_in(tpb), .closed_a_in(cl_a),
        .closed_b_in(cl_b), .swap_in(swap), .casc_mode_in(casc_mode), .ch_a_out(ch_a),
        .ch_b_out(ch_b));

    safety_sensor_and_interface #(.PERIOD_CYCLES(PER)) uut (.clk_in(clk_in), .rst_in(rst_in),
        .sensor1_ch_a_in(ch_a[0]), .sensor1_ch_b_in(ch_b[0]), .sensor2_ch_a_in(ch_a[1]),
        .sensor2_ch_b_in(ch_b[1]), .sensor3_ch_a_in(ch_a[2]), .sensor3_ch_b_in(ch_b[2]),
        .cascade_ch_a_in(ch_a[3]), .cascade_ch_b_in(ch_b[3]), .test_pulse_a_out(tpa),
        .test_pulse_b_out(tpb), .safety_out_a_out(sa), .safety_out_b_out(sb),
        .signal_out_out(so), .error_out(err), .ready_out(rdy), .cascaded_out(casc));

    // Counts cycles where both pulses are low together
    always @(posedge clk_in) if (!rst_in && tpa === 1'b0 && tpb === 1'b0) overlap++;

    function logic exp_safety(input logic [3:0] x, input logic [3:0] y);
        return &(x & y);
    endfunction : exp_safety

    function logic exp_signal(input logic [3:0] x, input logic [3:0] y);
        return &(x[2:0] & y[2:0]);
    endfunction : exp_signal

    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc

    // Reset, then wait for the run phase under a bound
    task start;
        int i;
        rst_in = 1'b1;
        cyc(8);
        rst_in = 1'b0;
        for (i = 0; i < 4 * PER && rdy !== 1'b1; i++) cyc(1);
        if (rdy !== 1'b1)
        begin
            fails++;
            finish_test;
        end
    endtask : start

    // Apply contact states and compare outputs after two idle samples
    task apply(input logic [3:0] x, input logic [3:0] y, input logic es, input logic eg);
        cl_a = x;
        cl_b = y;
        cyc(PER + 4);
        `CHK(sa, es)
        `CHK(sb, es)
        `CHK(so, eg)
    endtask : apply

    // Width of one low pulse on output A
    task pulse_width;
        int i, n;
        for (i = 0; i < 2 * PER && tpa !== 1'b0; i++) cyc(1);
        for (n = 0; n < 2 * PER && tpa === 1'b0; n++) cyc(1);
        `CHK(n, PULSE_CYCLES)
    endtask : pulse_width

    initial
    begin
        start;
        `CHK(casc, 1'b0)
        pulse_width;
        apply(4'hf, 4'hf, 1'b1, 1'b1);
        // Random contact patterns, each after a full opening
        for (int k = 0; k < 12; k++)
        begin
            r = $random(seed);
            a = r[5] ? 4'hf : r[3:0];
            b = r[6] ? a : r[11:8];
            apply(4'h0, 4'h0, 1'b0, 1'b0);
            apply(a, b, exp_safety(a, b), exp_signal(a, b));
        end
        // Partial operation blocks until the pair opens fully
        apply(4'hf, 4'he, 1'b0, 1'b0);
        apply(4'hf, 4'hf, 1'b0, 1'b0);
        apply(4'h0, 4'h0, 1'b0, 1'b0);
        apply(4'hf, 4'hf, 1'b1, 1'b1);
        // Swapped pulse on each pair latches a fault until reset
        for (int i = 0; i < 4; i++)
        begin
            start;
            `CHK(err, 1'b0)
            swap[i] = 1'b1;
            apply(4'hf, 4'hf, 1'b0, 1'b1);
            `CHK(err, 1'b1)
            swap = 4'h0;
            apply(4'hf, 4'hf, 1'b0, 1'b1);
            `CHK(err, 1'b1)
        end
        // Cascaded behind an upstream unit
        casc_mode = 1'b1;
        start;
        `CHK(casc, 1'b1)
        apply(4'hf, 4'hf, 1'b1, 1'b1);
        apply(4'h7, 4'h7, 1'b0, 1'b1);
        apply(4'hf, 4'h7, 1'b0, 1'b1);
        apply(4'hf, 4'hf, 1'b0, 1'b1);
        apply(4'h7, 4'h7, 1'b0, 1'b1);
        apply(4'hf, 4'hf, 1'b1, 1'b1);
        swap[0] = 1'b1;
        apply(4'hf, 4'hf, 1'b0, 1'b1);
        `CHK(err, 1'b1)
        `CHK(overlap, 0)
        finish_test;
    end
endmodule : safety_sensor_and_interface_tb
